// [rtl/adccmp_pkg.sv]
// adccmp_pkg: constants and types for the converter compare and input control slice
// assumes a 16-bit register port with byte offsets as printed, one 50 MHz clock
// How it works
// - after reset the converter is powered down, all registers at reset value
// - sequence-done and compare interrupts, each gated by its enable in control two
// - sixteen input enable bits, bit x connects digital buffer of analog pin x
// - a set input enable bit keeps its buffer on continuously, even during conversion
// - any write to the compare-above select register aborts the running sequence
// - select bit 0 flags result lower or same, 1 flags result strictly higher
// - select bits index conversion position; compare value comes from compare value entry n written at OFS_CMPV
// - a conversion meeting its condition sets its flag in compare flag status, unless a compare-above select write aborts in that same cycle
package adccmp_pkg;
  localparam logic [4:0] OFS_CTL2 = 5'h02; // converter_control_two
  localparam logic [4:0] OFS_STAT = 5'h06; // sticky event status, read clears
  localparam logic [4:0] OFS_MASK = 5'h08; // event mask
  localparam logic [4:0] OFS_CFLG = 5'h0a; // compare_flag_status
  localparam logic [4:0] OFS_DIEN = 5'h0c; // digital_input_buffer_enable
  localparam logic [4:0] OFS_CMPH = 5'h0e; // compare_higher_than_select
  localparam logic [4:0] OFS_CMPV = 5'h10; // compare value for conversion index in bits 13:10
  localparam int CTL2_PWR = 0; // power up
  localparam int CTL2_SCIE = 1; // seq_done_irq_enable
  localparam int CTL2_CMPIE = 2; // compare_irq_enable
  localparam int EV_SEQ = 0; // status bit: sequence complete
  localparam int EV_CMP = 1; // status bit: compare match
  localparam logic [15:0] RST_WORD = 16'h0000; // reset value of all registers
  localparam logic [3:0] LAST_CONV = 4'hf; // sequence holds 16 conversions

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_IDLE = 3'b010,
    ST_RUN = 3'b100
  } adccmp_seq_type;

  typedef struct packed {
    logic [15:0] ctl2;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [15:0] cflag;
    logic [15:0] dien;
    logic [15:0] cmph;
    logic [15:0][9:0] cval;
    adccmp_seq_type seq;
    logic [3:0] idx;
    logic [15:0] rdata;
    logic irq;
    logic busy;
  } adccmp_state_type;

  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } adccmp_bus_type;
endpackage

// [rtl/adccmp_ctrl.sv]
// adccmp_ctrl: register file, sequencer, compare flagging and interrupt for the converter
// assumes the analog core supplies one result with a valid pulse per conversion, same clock
//
// Strobed register access was decided locally.
`timescale 1ns/1ns
module adccmp_ctrl (
  input wire logic clk_sys, // 50 MHz clock
  input wire logic rst_b, // synchronous reset, active low
  input wire adccmp_pkg::adccmp_bus_type bus, // register port request
  input wire logic start, // start a sequence, one-cycle pulse
  input wire logic res_valid, // conversion result valid, one-cycle pulse
  input wire logic [9:0] res_data, // conversion result
  output logic [15:0] rdata, // read data, cycle after read strobe
  output logic [15:0] input_buffer_on, // digital buffer enables per analog pin
  output logic seq_busy, // sequence running
  output logic irq // level interrupt request
);
  adccmp_pkg::adccmp_state_type s_q;
  adccmp_pkg::adccmp_state_type s_d;
  logic hit;
  logic [1:0] ev;

  // comparison for the current conversion, operator and value by position
  always_comb
  begin
    if (s_q.cmph[s_q.idx])
      hit = res_data > s_q.cval[s_q.idx];
    else
      hit = res_data <= s_q.cval[s_q.idx];
  end

  // next state: bus writes, reads, sequencer, flags
  always_comb
  begin
    s_d = s_q;
    ev = 2'b00;
    s_d.rdata = 16'h0000;
    if (bus.rd)
    begin
      if (bus.addr == adccmp_pkg::OFS_CTL2)
        s_d.rdata = s_q.ctl2;
      else if (bus.addr == adccmp_pkg::OFS_STAT)
        s_d.rdata = {14'h0000, s_q.stat};
      else if (bus.addr == adccmp_pkg::OFS_MASK)
        s_d.rdata = {14'h0000, s_q.mask};
      else if (bus.addr == adccmp_pkg::OFS_CFLG)
        s_d.rdata = s_q.cflag;
      else if (bus.addr == adccmp_pkg::OFS_DIEN)
        s_d.rdata = s_q.dien;
      else if (bus.addr == adccmp_pkg::OFS_CMPH)
        s_d.rdata = s_q.cmph;
      else if (bus.addr == adccmp_pkg::OFS_CMPV)
        s_d.rdata = {6'h00, s_q.cval[0]};
      if (bus.addr == adccmp_pkg::OFS_STAT)
        s_d.stat = 2'b00; // read clears
    end
    if (bus.wr)
    begin
      if (bus.addr == adccmp_pkg::OFS_CTL2)
        s_d.ctl2 = bus.wdata;
      else if (bus.addr == adccmp_pkg::OFS_MASK)
        s_d.mask = bus.wdata[1:0];
      else if (bus.addr == adccmp_pkg::OFS_CFLG)
        s_d.cflag = s_q.cflag & ~bus.wdata; // write one clears
      else if (bus.addr == adccmp_pkg::OFS_DIEN)
        s_d.dien = bus.wdata;
      else if (bus.addr == adccmp_pkg::OFS_CMPH)
        s_d.cmph = bus.wdata;
      else if (bus.addr == adccmp_pkg::OFS_CMPV)
        s_d.cval[bus.wdata[13:10]] = bus.wdata[9:0];
    end
    // sequencer
    case (s_q.seq)
      adccmp_pkg::ST_OFF:
        if (s_q.ctl2[adccmp_pkg::CTL2_PWR])
          s_d.seq = adccmp_pkg::ST_IDLE;
      adccmp_pkg::ST_IDLE:
        if (start)
        begin
          s_d.seq = adccmp_pkg::ST_RUN;
          s_d.idx = 4'h0;
        end
      adccmp_pkg::ST_RUN:
        if (res_valid)
        begin
          if (hit)
          begin
            s_d.cflag[s_q.idx] = 1'b1;
            ev[adccmp_pkg::EV_CMP] = 1'b1;
          end
          if (s_q.idx == adccmp_pkg::LAST_CONV)
          begin
            s_d.seq = adccmp_pkg::ST_IDLE;
            ev[adccmp_pkg::EV_SEQ] = 1'b1;
          end
          else
            s_d.idx = s_q.idx + 4'h1;
        end
      default:
        s_d.seq = adccmp_pkg::ST_OFF;
    endcase
    // abort on compare select write, no remaining conversions
    if (bus.wr && bus.addr == adccmp_pkg::OFS_CMPH && s_q.seq == adccmp_pkg::ST_RUN)
    begin
      s_d.seq = adccmp_pkg::ST_IDLE;
      s_d.idx = 4'h0;
      ev = 2'b00;
      s_d.cflag = s_q.cflag;
    end
    if (!s_d.ctl2[adccmp_pkg::CTL2_PWR])
      s_d.seq = adccmp_pkg::ST_OFF;
    // events set over read clear
    s_d.stat = s_d.stat | ev;
    s_d.busy = (s_d.seq == adccmp_pkg::ST_RUN);
    s_d.irq = |(s_d.stat & s_d.mask &
      {s_d.ctl2[adccmp_pkg::CTL2_CMPIE], s_d.ctl2[adccmp_pkg::CTL2_SCIE]});
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.seq <= adccmp_pkg::ST_OFF;
    end
    else
      s_q <= s_d;
  end

  assign rdata = s_q.rdata;
  assign input_buffer_on = s_q.dien;
  assign seq_busy = s_q.busy;
  assign irq = s_q.irq;

  reset_off_a: assert property (@(posedge clk_sys) !rst_b |=> s_q.seq == adccmp_pkg::ST_OFF
    && irq == 1'b0 && input_buffer_on == 16'h0000) else $error("not off after reset");
  irq_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    irq |-> (s_q.ctl2[adccmp_pkg::CTL2_SCIE] || s_q.ctl2[adccmp_pkg::CTL2_CMPIE]))
    else $error("irq without local enable");
  dien_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.wr && bus.addr == adccmp_pkg::OFS_DIEN |=> input_buffer_on == $past(bus.wdata))
    else $error("input enable not stored");
  dien_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !(bus.wr && bus.addr == adccmp_pkg::OFS_DIEN) |=> $stable(input_buffer_on))
    else $error("input enable moved");
  abort_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.wr && bus.addr == adccmp_pkg::OFS_CMPH && seq_busy |=> !seq_busy)
    else $error("sequence not aborted");
  cmp_op_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_busy && res_valid && !bus.wr && s_q.cmph[s_q.idx]
    && res_data > s_q.cval[s_q.idx] |=> s_q.cflag[$past(s_q.idx)])
    else $error("higher compare not flagged");
  cmp_low_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_busy && res_valid && !bus.wr && !s_q.cmph[s_q.idx]
    && res_data <= s_q.cval[s_q.idx] |=> s_q.cflag[$past(s_q.idx)] && s_q.stat[1])
    else $error("lower compare not flagged");
  idx_step_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    seq_busy && res_valid && !bus.wr && s_q.idx != 4'hf |=> s_q.idx == $past(s_q.idx) + 4'h1)
    else $error("conversion index wrong");
  abort_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    bus.wr && bus.addr == adccmp_pkg::OFS_CMPH && seq_busy
    |=> s_q.seq == adccmp_pkg::ST_IDLE && (!s_q.stat[0] || $past(s_q.stat[0])))
    else $error("abort not idle");
  // main scenarios reached: done, abort, interrupt, compare hit; idle with power off cannot occur, power off forces ST_OFF
  seq_done_c: cover property (@(posedge clk_sys) disable iff (!rst_b) s_q.stat[0]);
  abort_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    bus.wr && bus.addr == adccmp_pkg::OFS_CMPH && seq_busy);
  irq_c: cover property (@(posedge clk_sys) disable iff (!rst_b) irq);
  cmp_hit_c: cover property (@(posedge clk_sys) disable iff (!rst_b) seq_busy && res_valid && hit);
  pwr_drop_c: cover property (@(posedge clk_sys) disable iff (!rst_b)
    s_q.seq == adccmp_pkg::ST_IDLE && !s_q.ctl2[adccmp_pkg::CTL2_PWR]);
endmodule // adccmp_ctrl

// [test/adccmp_core_model.sv]
// adccmp_core_model: analog core stand-in that returns one result per conversion
// assumes go is pulsed by the bench once the sequencer is already busy
`timescale 1ns/1ns
module adccmp_core_model (
  input wire logic clk_sys, // 50 MHz clock
  input wire logic go, // begin emitting results
  input wire logic [4:0] cnt, // number of results to emit
  input wire logic [3:0] gap, // idle cycles between results, 0 is prompt
  output logic res_valid, // result valid pulse
  output logic [9:0] res_data // result, inverted garbage between pulses
);
  // result of conversion n equals n, so the bench can predict every compare
  initial
  begin
    res_valid = 1'b0;
    res_data = 10'h3ff;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        for (int n = 0; n < cnt; n++)
        begin
          res_valid <= 1'b1;
          res_data <= n[9:0];
          @(posedge clk_sys);
          if (gap != 4'h0)
          begin
            res_valid <= 1'b0;
            res_data <= ~n[9:0]; // stale value never lingers
            repeat (gap) @(posedge clk_sys);
          end
        end
        res_valid <= 1'b0;
        res_data <= 10'h2aa;
      end
    end
  end
endmodule // adccmp_core_model

// [test/tb.sv]
// tb: self-checking bench for the converter compare and input control slice
// assumes adccmp_ctrl and adccmp_core_model are compiled before it
`timescale 1ns/1ns
module tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  adccmp_pkg::adccmp_bus_type bus = '0;
  logic start = 1'b0;
  logic go = 1'b0;
  logic [4:0] cnt = 5'd16;
  logic [3:0] gap = 4'h0;
  logic res_valid;
  logic [9:0] res_data;
  logic [15:0] rdata;
  logic [15:0] input_buffer_on;
  logic seq_busy;
  logic irq;
  logic [15:0] v;
  int error_cnt = 0;
  int tests_run = 0;
  // 20 ns clock
  always #10 clk_sys = ~clk_sys;
  adccmp_ctrl dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .start(start),
    .res_valid(res_valid), .res_data(res_data), .rdata(rdata),
    .input_buffer_on(input_buffer_on), .seq_busy(seq_busy), .irq(irq));
  adccmp_core_model core_u (.clk_sys(clk_sys), .go(go), .cnt(cnt), .gap(gap),
    .res_valid(res_valid), .res_data(res_data));
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rdc(input string what, input logic [4:0] a, input logic [15:0] e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk(what, e, rdata);
    @(posedge clk_sys);
  endtask
  task automatic kick(input logic [3:0] g, input logic [4:0] c);
    gap <= g;
    cnt <= c;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
  endtask
  task automatic t_reset;
    rdc("ctl2", adccmp_pkg::OFS_CTL2, 16'h0000);
    rdc("dien", adccmp_pkg::OFS_DIEN, 16'h0000);
    rdc("cmph", adccmp_pkg::OFS_CMPH, 16'h0000);
    kick(4'h1, 5'd2);
    chk("busy_off", 16'h0000, {15'h0, seq_busy});
  endtask
  task automatic t_dien;
    wr(adccmp_pkg::OFS_DIEN, 16'ha5c3);
    chk("buf_on", 16'ha5c3, input_buffer_on);
    rdc("dien_rd", adccmp_pkg::OFS_DIEN, 16'ha5c3);
    rdc("unmapped", 5'h1e, 16'h0000);
  endtask
  task automatic t_abort;
    wr(adccmp_pkg::OFS_CTL2, 16'h0003);
    wr(adccmp_pkg::OFS_MASK, 16'h0001);
    kick(4'h3, 5'd3);
    repeat (4) @(posedge clk_sys);
    chk("busy_run", 16'h0001, {15'h0, seq_busy});
    chk("buf_run", 16'ha5c3, input_buffer_on);
    wr(adccmp_pkg::OFS_CMPH, 16'h00f0);
    chk("busy_abort", 16'h0000, {15'h0, seq_busy});
    repeat (12) @(posedge clk_sys);
    chk("irq_abort", 16'h0000, {15'h0, irq});
    rdc("cmph_rd", adccmp_pkg::OFS_CMPH, 16'h00f0);
    bus <= '{addr: adccmp_pkg::OFS_STAT, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 chk("seq_done_abort", 16'h0000, rdata & 16'h0001);
    @(posedge clk_sys);
  endtask
  task automatic t_seq;
    logic [15:0] ef;
    for (int n = 0; n < 16; n++) wr(adccmp_pkg::OFS_CMPV, {2'b00, n[3:0], 6'h00, 4'hf - n[3:0]});
    for (int n = 0; n < 16; n++) ef[n] = (n >= 4 && n < 8) ? (n > 15 - n) : (n <= 15 - n);
    wr(adccmp_pkg::OFS_CFLG, 16'hffff);
    kick(4'h0, 5'd16);
    for (int i = 0; i < 100 && seq_busy; i++) @(posedge clk_sys);
    chk("irq_done", 16'h0001, {15'h0, irq});
    rdc("cflag", adccmp_pkg::OFS_CFLG, ef);
    rdc("stat", adccmp_pkg::OFS_STAT, 16'h0003);
    chk("irq_clr", 16'h0000, {15'h0, irq});
  endtask
  task automatic end_of_test;
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // watchdog well beyond the hundred or so cycles the scenarios need
  initial
  begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  // reset for 8 cycles, then the scenarios in order
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_dien();
    t_abort();
    t_seq();
    end_of_test();
  end
endmodule // tb
